// ---- logic/buck_cfg_defines.svh ----
`ifndef BUCK_CFG_DEFINES_SVH
`define BUCK_CFG_DEFINES_SVH

// Register offsets on the internal register port
`define CONV0_LIMIT_SLEW_ADDR 8'h03
`define CONV1_MODE_ENABLE_ADDR 8'h04
`define CONV1_LIMIT_SLEW_ADDR 8'h05
`define CONV0_OUTPUT_LEVEL_ADDR 8'h06

// Field positions of the limit and ramp registers
`define LIMIT_MSB 5
`define LIMIT_LSB 3
`define RAMP_MSB 2
`define RAMP_LSB 0

// Field positions of the mode and enable register
`define FORCED_PWM_BIT 3
`define DISCHARGE_BIT 2
`define PIN_GATING_BIT 1
`define ON_BIT 0

// Reset values
`define LIMIT_SLEW_RESET 8'h1C
`define MODE_ENABLE_RESET 8'h0F
`define OUTPUT_LEVEL_RESET 8'hFF
`define LIMIT_RESET 3'h3
`define RAMP_RESET 3'h4

// Highest legal current limit code, lowest legal ramp code
`define LIMIT_MAX_CODE 3'h3
`define RAMP_MIN_CODE 3'h2

// Value read back from an unmapped offset
`define UNMAPPED_READ 8'h00

`endif

// ---- logic/buck_cfg_pkg.sv ----
`default_nettype none
package buck_cfg_pkg;

    // Current limit codes
    typedef enum logic [2:0] {
        LIMIT_1A5 = 3'h0,
        LIMIT_2A0 = 3'h1,
        LIMIT_2A5 = 3'h2,
        LIMIT_3A0 = 3'h3
    } current_limit_t;

    // Ramp rate codes in mV/us
    typedef enum logic [2:0] {
        RAMP_10 = 3'h2,
        RAMP_7P5 = 3'h3,
        RAMP_3P8 = 3'h4,
        RAMP_1P9 = 3'h5,
        RAMP_0P94 = 3'h6,
        RAMP_0P47 = 3'h7
    } ramp_rate_t;

    // Number of converters carrying a limit and ramp register
    localparam int unsigned NUM_CONV = 2;

endpackage : buck_cfg_pkg
`default_nettype wire

// ---- logic/buck_converter_config_regs.sv ----
`timescale 1ns/1ps
`include "buck_cfg_defines.svh"
`default_nettype none
module buck_converter_config_regs (
    input wire logic core_clk,
    input wire logic rst,
    // Register port from the serial slave, same clock
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // External enable pin, asynchronous
    input wire logic en_pin,
    // Analog regulator controls
    output logic [2:0] conv0_current_limit,
    output logic [2:0] conv0_ramp_rate,
    output logic [2:0] conv1_current_limit,
    output logic [2:0] conv1_ramp_rate,
    output logic conv1_forced_pwm,
    output logic conv1_pin_gating,
    output logic conv1_on,
    output logic conv1_run,
    output logic conv1_discharge_on,
    output logic [7:0] conv0_output_level,
    // Reserved code present in a limit or ramp field, per converter
    output logic [1:0] reserved_code
);

    // Offset match, used by write and read decode
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        addr_is = (a == ref_a);
    endfunction : addr_is

    // Reserved limit or ramp code in one register, shared by the flags and their check
    function automatic logic is_reserved(input logic [7:0] r);
        is_reserved = (r[`LIMIT_MSB:`LIMIT_LSB] > `LIMIT_MAX_CODE) || (r[`RAMP_MSB:`RAMP_LSB] < `RAMP_MIN_CODE);
    endfunction : is_reserved

    // Storage
    logic [7:0] limit_slew_q [buck_cfg_pkg::NUM_CONV];
    logic [7:0] mode_enable_q;
    logic [7:0] output_level_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic run_q;
    logic discharge_q;
    logic [1:0] reserved_q;

    // Address decode
    wire logic hit_limit0 = addr_is(reg_addr, `CONV0_LIMIT_SLEW_ADDR);
    wire logic hit_mode1 = addr_is(reg_addr, `CONV1_MODE_ENABLE_ADDR);
    wire logic hit_limit1 = addr_is(reg_addr, `CONV1_LIMIT_SLEW_ADDR);
    wire logic hit_level0 = addr_is(reg_addr, `CONV0_OUTPUT_LEVEL_ADDR);
    wire logic [1:0] hit_limit = {hit_limit1, hit_limit0};

    // Read selection; unmapped offsets return zero
    wire logic [7:0] rd_sel = hit_limit0 ? limit_slew_q[0] :
                              hit_mode1 ? mode_enable_q :
                              hit_limit1 ? limit_slew_q[1] :
                              hit_level0 ? output_level_q : `UNMAPPED_READ;

    // Effective run: pin only matters when gating is selected
    wire logic on_bit = mode_enable_q[`ON_BIT];
    wire logic gate_bit = mode_enable_q[`PIN_GATING_BIT];
    wire logic run_d = on_bit & (~gate_bit | pin_sync_q);
    // Discharge resistor only while the converter is not running
    wire logic discharge_d = mode_enable_q[`DISCHARGE_BIT] & ~run_d;

    // Limit and ramp registers, one per converter. Writes land at any time,
    // the regulator need not be stopped, so there is no run interlock here.
    genvar gi;
    generate
        for (gi = 0; gi < buck_cfg_pkg::NUM_CONV; gi++) begin : g_conv
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    limit_slew_q[gi] <= `LIMIT_SLEW_RESET;
                end else if (reg_wr && hit_limit[gi]) begin
                    limit_slew_q[gi] <= reg_wdata;
                end
            end
            // Flag reserved codes; hardware still passes them on unchanged
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    reserved_q[gi] <= 1'b0;
                end else begin
                    reserved_q[gi] <= is_reserved(limit_slew_q[gi]);
                end
            end
        end
    endgenerate

    // Mode/enable and output level registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_enable_q <= `MODE_ENABLE_RESET;
            output_level_q <= `OUTPUT_LEVEL_RESET;
        end else begin
            if (reg_wr && hit_mode1) begin
                mode_enable_q <= reg_wdata;
            end
            if (reg_wr && hit_level0) begin
                output_level_q <= reg_wdata;
            end
        end
    end

    // Enable pin synchroniser; only the second stage feeds logic
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= en_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Registered run and discharge controls, glitch free toward the analog side
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            discharge_q <= 1'b1;
        end else begin
            run_q <= run_d;
            discharge_q <= discharge_d;
        end
    end

    // Read data, one cycle after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rd_sel;
            end
        end
    end

    // Field outputs straight from the storage flops
    assign conv0_current_limit = limit_slew_q[0][`LIMIT_MSB:`LIMIT_LSB];
    assign conv0_ramp_rate = limit_slew_q[0][`RAMP_MSB:`RAMP_LSB];
    assign conv1_current_limit = limit_slew_q[1][`LIMIT_MSB:`LIMIT_LSB];
    assign conv1_ramp_rate = limit_slew_q[1][`RAMP_MSB:`RAMP_LSB];
    assign conv1_forced_pwm = mode_enable_q[`FORCED_PWM_BIT];
    assign conv1_pin_gating = gate_bit;
    assign conv1_on = on_bit;
    assign conv1_run = run_q;
    assign conv1_discharge_on = discharge_q;
    assign conv0_output_level = output_level_q;
    assign reserved_code = reserved_q;
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // Limit write is visible on the next cycle, running or not
    a_limit0_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_limit0) |=> conv0_current_limit == $past(reg_wdata[5:3]))
        else $error("converter 0 limit write not applied");

    a_limit1_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_limit1) |=> conv1_current_limit == $past(reg_wdata[5:3]))
        else $error("converter 1 limit write not applied");

    a_ramp0_hold: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && hit_limit0) |=> $stable(conv0_ramp_rate))
        else $error("converter 0 ramp changed without write");

    a_ramp1_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_limit1) |=> conv1_ramp_rate == $past(reg_wdata[2:0]))
        else $error("converter 1 ramp write not applied");

    a_limit0_reserved: assert property (@(posedge core_clk) disable iff (rst)
        (conv0_current_limit > 3'h3) |=> reserved_code[0])
        else $error("reserved limit code not flagged");

    a_mode_pwm: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_mode1) |=> conv1_forced_pwm == $past(reg_wdata[3]))
        else $error("forced pwm bit not applied");

    a_run_gated: assert property (@(posedge core_clk) disable iff (rst)
        (conv1_on && conv1_pin_gating && !pin_sync_q) |=> !conv1_run)
        else $error("converter runs without enable pin");

    a_run_off: assert property (@(posedge core_clk) disable iff (rst)
        !conv1_on ##1 !conv1_on |-> !conv1_run)
        else $error("converter runs with on bit clear");

    a_pin_path: assert property (@(posedge core_clk) disable iff (rst)
        (conv1_on && conv1_pin_gating) ##1 (conv1_on && conv1_pin_gating) |-> conv1_run == $past(pin_sync_q))
        else $error("run does not follow the enable pin");

    a_discharge: assert property (@(posedge core_clk) disable iff (rst)
        conv1_discharge_on |-> !conv1_run)
        else $error("discharge connected while running");

    // Converter 0 limit only moves on its own write
    a_limit0_hold: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && hit_limit0) |=> $stable(conv0_current_limit))
        else $error("converter 0 limit changed without write");

    // Converter 1 limit only moves on its own write
    a_limit1_hold: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && hit_limit1) |=> $stable(conv1_current_limit))
        else $error("converter 1 limit changed without write");

    // Converter 1 ramp only moves on its own write
    a_ramp1_hold: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && hit_limit1) |=> $stable(conv1_ramp_rate))
        else $error("converter 1 ramp changed without write");

    // Converter 0 ramp write lands on the next cycle
    a_ramp0_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_limit0) |=> conv0_ramp_rate == $past(reg_wdata[2:0]))
        else $error("converter 0 ramp write not applied");

    // Mode and enable bits only move on their own write
    a_mode_stable: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && hit_mode1) |=> $stable(mode_enable_q))
        else $error("mode register changed without write");

    // On bit write lands on the next cycle
    a_on_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_mode1) |=> conv1_on == $past(reg_wdata[`ON_BIT]))
        else $error("on bit write not applied");

    // Pin gating bit write lands on the next cycle
    a_gating_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_mode1) |=> conv1_pin_gating == $past(reg_wdata[`PIN_GATING_BIT]))
        else $error("pin gating bit write not applied");

    // Discharge select bit write lands on the next cycle
    a_discharge_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && hit_mode1) |=> mode_enable_q[`DISCHARGE_BIT] == $past(reg_wdata[`DISCHARGE_BIT]))
        else $error("discharge bit write not applied");

    // A converter switched off by software gets its resistor when selected
    a_discharge_set: assert property (@(posedge core_clk) disable iff (rst)
        (mode_enable_q[`DISCHARGE_BIT] && !conv1_on) |=> conv1_discharge_on)
        else $error("discharge missing while converter off");

    // Resistor stays disconnected when not selected
    a_discharge_clear: assert property (@(posedge core_clk) disable iff (rst)
        !mode_enable_q[`DISCHARGE_BIT] |=> !conv1_discharge_on)
        else $error("discharge connected while deselected");

    // With gating clear the pin is ignored and the on bit alone runs the converter
    a_run_direct: assert property (@(posedge core_clk) disable iff (rst)
        (conv1_on && !conv1_pin_gating) |=> conv1_run)
        else $error("converter stopped with gating clear");

    // With gating set, a high pin and the on bit run the converter
    a_run_pin_high: assert property (@(posedge core_clk) disable iff (rst)
        (conv1_on && conv1_pin_gating && pin_sync_q) |=> conv1_run)
        else $error("converter stopped with pin high");

    // Reserved converter 1 limit code is flagged one cycle later
    a_limit1_reserved: assert property (@(posedge core_clk) disable iff (rst)
        (conv1_current_limit > `LIMIT_MAX_CODE) |=> reserved_code[1])
        else $error("reserved converter 1 limit not flagged");

    // Reserved converter 1 ramp code is flagged one cycle later
    a_ramp1_reserved: assert property (@(posedge core_clk) disable iff (rst)
        (conv1_ramp_rate < `RAMP_MIN_CODE) |=> reserved_code[1])
        else $error("reserved converter 1 ramp not flagged");

    // A legal converter 0 setting never leaves its flag up
    a_legal_clear: assert property (@(posedge core_clk) disable iff (rst)
        !is_reserved(limit_slew_q[0]) |=> !reserved_code[0])
        else $error("converter 0 flag set for legal codes");

    // Reset loads limit code 3 into both converters
    a_reset_limit: assert property (@(posedge core_clk)
        rst |-> (conv0_current_limit == `LIMIT_RESET) && (conv1_current_limit == `LIMIT_RESET))
        else $error("limit reset value wrong");

    // Reset loads ramp code 4 into both converters
    a_reset_ramp: assert property (@(posedge core_clk)
        rst |-> (conv0_ramp_rate == `RAMP_RESET) && (conv1_ramp_rate == `RAMP_RESET))
        else $error("ramp reset value wrong");

    // Reset sets mode, discharge, gating and on bits
    a_reset_mode: assert property (@(posedge core_clk)
        rst |-> mode_enable_q == `MODE_ENABLE_RESET)
        else $error("mode register reset value wrong");

    // Read answer comes exactly one cycle after the strobe
    a_rvalid_set: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd |=> reg_rvalid)
        else $error("read answer missing");

    // No answer without a request
    a_rvalid_clear: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> !reg_rvalid)
        else $error("read answer without request");

    // Mode register reads back the value held at the request edge
    a_read_data: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && hit_mode1) |=> reg_rdata == $past(mode_enable_q))
        else $error("mode register read back wrong");

endmodule : buck_converter_config_regs
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    logic core_clk, rst, reg_wr, reg_rd, en_pin, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, conv0_output_level;
    logic [2:0] conv0_current_limit, conv0_ramp_rate, conv1_current_limit, conv1_ramp_rate;
    logic conv1_forced_pwm, conv1_pin_gating, conv1_on, conv1_run, conv1_discharge_on;
    logic [1:0] reserved_code;
    int fails = 0;
    int compares = 0;

    buck_converter_config_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .en_pin(en_pin), .conv0_current_limit(conv0_current_limit), .conv0_ramp_rate(conv0_ramp_rate),
        .conv1_current_limit(conv1_current_limit), .conv1_ramp_rate(conv1_ramp_rate),
        .conv1_forced_pwm(conv1_forced_pwm), .conv1_pin_gating(conv1_pin_gating), .conv1_on(conv1_on),
        .conv1_run(conv1_run), .conv1_discharge_on(conv1_discharge_on),
        .conv0_output_level(conv0_output_level), .reserved_code(reserved_code));

    // Free-running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Inputs always move 1 ns after the rising edge, clear of the sampling point
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // One-cycle write strobe; fields are settled when this returns
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
    endtask : wr

    // One-cycle read strobe; data and valid are judged in the answer cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        step(1);
        reg_rd = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, exp)
    endtask : rd_chk

    // Power-on state with the pin high, so the converter runs and discharge is off
    task automatic reset_values;
        step(3);
        `CHK(conv0_current_limit, 3'h3)
        `CHK(conv0_ramp_rate, 3'h4)
        `CHK(conv1_current_limit, 3'h3)
        `CHK(conv1_ramp_rate, 3'h4)
        `CHK(conv1_forced_pwm, 1'b1)
        `CHK(conv1_discharge_on, 1'b0)
        `CHK({conv1_pin_gating, conv1_run}, 2'b11)
        `CHK(conv1_on, 1'b1)
        rd_chk(`CONV0_LIMIT_SLEW_ADDR, {2'h0, 3'h3, 3'h4});
        rd_chk(`CONV1_MODE_ENABLE_ADDR, {4'h0, 4'hF});
        rd_chk(`CONV1_LIMIT_SLEW_ADDR, {2'h0, 3'h3, 3'h4});
        rd_chk(`CONV0_OUTPUT_LEVEL_ADDR, 8'hFF);
    endtask : reset_values

    // Every legal limit and ramp code rewritten back to back while converter 1 keeps running
    task automatic limit_ramp_running;
        logic [2:0] lim;
        logic [2:0] ramp;
        for (int j = 0; j < 6; j++) begin
            lim = 3'(j % 4);
            ramp = 3'(j + 2);
            wr(`CONV0_LIMIT_SLEW_ADDR, {2'h0, lim, ramp});
            `CHK({conv0_current_limit, conv0_ramp_rate}, {lim, ramp})
            wr(`CONV1_LIMIT_SLEW_ADDR, {2'h0, 3'h3 - lim, ramp});
            `CHK({conv1_current_limit, conv1_ramp_rate}, {3'h3 - lim, ramp})
            `CHK(conv1_run, 1'b1)
            rd_chk(`CONV0_LIMIT_SLEW_ADDR, {2'h0, lim, ramp});
            rd_chk(`CONV1_LIMIT_SLEW_ADDR, {2'h0, 3'h3 - lim, ramp});
        end
    endtask : limit_ramp_running

    // All sixteen mode/enable settings against both pin levels
    task automatic enable_table;
        logic [3:0] b;
        logic run;
        for (int i = 0; i < 32; i++) begin
            b = i[3:0];
            en_pin = i[4];
            wr(`CONV1_MODE_ENABLE_ADDR, {4'h0, b});
            step(3);
            run = b[0] & (en_pin | ~b[1]);
            `CHK(conv1_forced_pwm, b[3])
            `CHK(conv1_discharge_on, b[2] & ~run)
            `CHK({conv1_pin_gating, conv1_run}, {b[1], run})
            `CHK(conv1_on, b[0])
            rd_chk(`CONV1_MODE_ENABLE_ADDR, {4'h0, b});
        end
    endtask : enable_table

    // Pin drop reaches the converter three edges later through the synchroniser
    task automatic pin_latency;
        wr(`CONV1_MODE_ENABLE_ADDR, 8'h0F);
        step(3);
        en_pin = 1'b0;
        step(2);
        `CHK(conv1_run, 1'b1)
        step(1);
        `CHK({conv1_run, conv1_discharge_on}, 2'b01)
        en_pin = 1'b1;
    endtask : pin_latency

    // Unmapped writes leave the map alone; reserved codes are flagged, not altered
    task automatic unmapped_reserved;
        wr(8'h07, 8'h55);
        wr(`CONV0_OUTPUT_LEVEL_ADDR, 8'h5A);
        `CHK(conv0_output_level, 8'h5A)
        rd_chk(8'h07, 8'h00);
        rd_chk(`CONV1_MODE_ENABLE_ADDR, 8'h0F);
        wr(`CONV0_LIMIT_SLEW_ADDR, {2'h0, 3'h5, 3'h2});
        step(1);
        `CHK({reserved_code, conv0_current_limit}, {2'b01, 3'h5})
        wr(`CONV1_LIMIT_SLEW_ADDR, {2'h0, 3'h0, 3'h1});
        step(1);
        `CHK({reserved_code, conv1_ramp_rate}, {2'b11, 3'h1})
    endtask : unmapped_reserved

    // Verdict and end of run
    task automatic close_out;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out

    // Main sequence after a two-cycle reset
    initial begin
        {rst, reg_wr, reg_rd, en_pin, reg_addr, reg_wdata} = {4'b1001, 16'h0000};
        step(2);
        rst = 1'b0;
        reset_values();
        limit_ramp_running();
        enable_table();
        pin_latency();
        unmapped_reserved();
        close_out();
    end

    // Watchdog: the tests need well under 2,000 cycles
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
